// >>> gpib_fast_pkg.sv
// Shared constants, timing figures and state types for the fast transfer configuration block.
// Assumes a single 200 MHz clock; every bus line is active low on the wire.
package gpib_fast_pkg;

	localparam int CLK_PERIOD_NS = 5;

	// Least times round up to whole cycles, never below one cycle.
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// Command codes, seven bits; the eighth data line is ignored for commands.
	localparam logic [6:0] CFG_ENABLE_MSG   = 7'h1f;
	localparam logic [2:0] SEC_CFG_GROUP    = 3'h6;
	localparam int         SEC_GROUP_LSB    = 4;
	localparam int         CABLE_LEN_W      = 4;
	localparam logic [3:0] CABLE_LEN_RST    = 4'h0;

	// Handshake timing in nanoseconds and the derived cycle counts.
	localparam int STD_SETTLE_NS        = 2000;
	localparam int FAST_SETTLE_BASE_NS  = 40;
	localparam int FAST_PER_METRE_NS    = 5;
	localparam int FAST_DAV_PULSE_NS    = 40;
	localparam int FAST_HOLD_NS         = 45;
	localparam int CNT_W                = 10;

	localparam logic [9:0] STD_SETTLE_CYC       = 10'(ns_to_cyc(STD_SETTLE_NS));
	localparam logic [9:0] FAST_SETTLE_BASE_CYC = 10'(ns_to_cyc(FAST_SETTLE_BASE_NS));
	localparam logic [9:0] FAST_PER_METRE_CYC   = 10'(ns_to_cyc(FAST_PER_METRE_NS));
	localparam logic [9:0] FAST_DAV_PULSE_CYC   = 10'(ns_to_cyc(FAST_DAV_PULSE_NS));
	localparam logic [9:0] FAST_HOLD_CYC        = 10'(ns_to_cyc(FAST_HOLD_NS));

	typedef enum logic [1:0] {
		CFG_IDLE,
		CFG_ARMED
	} cfg_state_t;

	typedef enum logic [1:0] {
		AH_OFF,
		AH_READY,
		AH_ACCEPTED
	} ah_state_t;

	typedef enum logic [2:0] {
		SH_IDLE,
		SH_SETTLE,
		SH_STD_DAV,
		SH_FAST_DAV,
		SH_FAST_HOLD
	} sh_state_t;

endpackage

// >>> line_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous bus lines.
// Assumes the lines are levels; a change is taken once stages two and three agree.
`timescale 1ns/1ps
module line_sync #(
	parameter int W = 12
) (
	// Clock, reset and enable
	input  wire logic         mclk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         ce_i,
	// Lines
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_r;

	// Resting level of every line is released, i.e. high.
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s1_r <= '1;
			s2_r <= '1;
			s3_r <= '1;
		end else if (ce_i) begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Bits only move where the last two stages agree, which rejects single-cycle glitches.
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q_r <= '1;
		end else if (ce_i) begin
			q_r <= (q_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
		end
	end

	assign q_o = q_r;

endmodule // line_sync

// >>> gpib_fast_cfg.sv
// Device-side bus handshake with fast non-interlocked mode and cable-length configuration.
// Assumes addressing is decoded upstream and the open-drain wiring is resolved outside.
`timescale 1ns/1ps
module gpib_fast_cfg (
	// Clock, reset and enable
	input  wire logic       mclk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       ce_i,
	// Bus data lines
	input  wire logic [7:0] dio_i,
	output logic      [7:0] dio_o,
	output logic            dio_oe_n_o,
	// Bus handshake and attention lines
	input  wire logic       atn_n_i,
	input  wire logic       dav_n_i,
	output logic            dav_n_o,
	output logic            dav_oe_n_o,
	input  wire logic       nrfd_n_i,
	output logic            nrfd_n_o,
	output logic            nrfd_oe_n_o,
	input  wire logic       ndac_n_i,
	output logic            ndac_n_o,
	output logic            ndac_oe_n_o,
	// Addressing from upstream decode
	input  wire logic       talk_addr_i,
	input  wire logic       listen_addr_i,
	// Received bytes
	input  wire logic       rx_ready_i,
	output logic            rx_valid_o,
	output logic [7:0]      rx_data_o,
	output logic            rx_cmd_o,
	// Bytes to send
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	output logic            tx_ready_o,
	// Status
	output logic            fast_cfg_o,
	output logic [3:0]      cable_len_o,
	output logic            fast_active_o
);

	logic [11:0] sync_q;
	logic [7:0]  bus_byte;
	logic        atn;
	logic        dav;
	logic        nrfd_rel;
	logic        ndac_rel;
	logic        dav_d_r;

	line_sync #(
		.W (12)
	) u_sync (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.d_i       ({ndac_n_i, nrfd_n_i, dav_n_i, atn_n_i, dio_i}),
		.q_o       (sync_q)
	);

	assign bus_byte = ~sync_q[7:0];
	assign atn      = ~sync_q[8];
	assign dav      = ~sync_q[9];
	assign nrfd_rel = sync_q[10];
	assign ndac_rel = sync_q[11];

	gpib_fast_pkg::cfg_state_t cfg_st_r;
	gpib_fast_pkg::ah_state_t  ah_st_r;
	gpib_fast_pkg::sh_state_t  sh_st_r;

	logic                                    cfg_done_r;
	logic [gpib_fast_pkg::CABLE_LEN_W-1:0]   cable_len_r;
	logic [gpib_fast_pkg::CNT_W-1:0]         fast_settle_r;
	logic [gpib_fast_pkg::CNT_W-1:0]         cnt_r;
	logic                                    fast_byte_r;
	logic                                    cmd_take;
	logic                                    ah_on;
	logic                                    fast_rx;
	logic                                    dav_fall;
	logic                                    nrfd_rel_r;
	logic                                    ndac_rel_r;
	logic                                    dav_rel_r;
	logic [7:0]                              dio_r;
	logic                                    dio_drive_r;
	logic                                    rx_valid_r;
	logic [7:0]                              rx_data_r;
	logic                                    rx_cmd_r;
	logic                                    tx_ready_r;

	assign dav_fall = dav & ~dav_d_r;
	assign ah_on    = atn | listen_addr_i;
	// Commands always go interlocked; fast reception needs configuration and listen address.
	assign fast_rx  = cfg_done_r & listen_addr_i & ~atn;
	// Same condition as the acceptor's take, so a refused byte never counts for configuration.
	assign cmd_take = (ah_st_r == gpib_fast_pkg::AH_READY) & dav_fall & nrfd_rel_r & atn;

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dav_d_r <= 1'b0;
		end else if (ce_i) begin
			dav_d_r <= dav;
		end
	end

	// Configuration sequence watcher on accepted command bytes.
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cfg_st_r      <= gpib_fast_pkg::CFG_IDLE;
			cfg_done_r    <= 1'b0;
			cable_len_r   <= gpib_fast_pkg::CABLE_LEN_RST;
			fast_settle_r <= gpib_fast_pkg::FAST_SETTLE_BASE_CYC;
		end else if (ce_i && cmd_take) begin
			unique case (cfg_st_r)
				gpib_fast_pkg::CFG_IDLE: begin
					if (bus_byte[6:0] == gpib_fast_pkg::CFG_ENABLE_MSG) begin
						cfg_st_r <= gpib_fast_pkg::CFG_ARMED;
					end
				end
				gpib_fast_pkg::CFG_ARMED: begin
					// Any other byte drops the arming and leaves the speed setting alone.
					cfg_st_r <= gpib_fast_pkg::CFG_IDLE;
					if (bus_byte[6:gpib_fast_pkg::SEC_GROUP_LSB] == gpib_fast_pkg::SEC_CFG_GROUP) begin
						cable_len_r   <= bus_byte[3:0];
						cfg_done_r    <= 1'b1;
						fast_settle_r <= gpib_fast_pkg::FAST_SETTLE_BASE_CYC
							+ 10'(bus_byte[3:0]) * gpib_fast_pkg::FAST_PER_METRE_CYC;
					end
				end
				default: begin
					cfg_st_r <= gpib_fast_pkg::CFG_IDLE;
				end
			endcase
		end
	end

	// Acceptor handshake.
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ah_st_r    <= gpib_fast_pkg::AH_OFF;
			nrfd_rel_r <= 1'b1;
			ndac_rel_r <= 1'b1;
			rx_valid_r <= 1'b0;
			rx_data_r  <= 8'h00;
			rx_cmd_r   <= 1'b0;
		end else if (ce_i) begin
			rx_valid_r <= 1'b0;
			unique case (ah_st_r)
				gpib_fast_pkg::AH_OFF: begin
					nrfd_rel_r <= 1'b1;
					ndac_rel_r <= 1'b1;
					if (ah_on) begin
						ah_st_r    <= gpib_fast_pkg::AH_READY;
						nrfd_rel_r <= 1'b0;
						ndac_rel_r <= 1'b0;
					end
				end
				gpib_fast_pkg::AH_READY: begin
					// Data is only invited when the consumer can take it; there is no buffer.
					nrfd_rel_r <= atn | rx_ready_i;
					// A released acceptance line before valid data tells the talker we are fast.
					ndac_rel_r <= fast_rx & rx_ready_i;
					if (!ah_on) begin
						ah_st_r <= gpib_fast_pkg::AH_OFF;
					end else if (dav_fall && nrfd_rel_r) begin
						rx_valid_r <= 1'b1;
						rx_data_r  <= bus_byte;
						rx_cmd_r   <= atn;
						if (fast_rx) begin
							ah_st_r <= gpib_fast_pkg::AH_ACCEPTED;
						end else begin
							ah_st_r    <= gpib_fast_pkg::AH_ACCEPTED;
							nrfd_rel_r <= 1'b0;
							ndac_rel_r <= 1'b1;
						end
					end
				end
				gpib_fast_pkg::AH_ACCEPTED: begin
					if (!dav) begin
						ah_st_r    <= ah_on ? gpib_fast_pkg::AH_READY : gpib_fast_pkg::AH_OFF;
						ndac_rel_r <= ~ah_on;
						nrfd_rel_r <= ~ah_on;
					end
				end
				default: begin
					ah_st_r <= gpib_fast_pkg::AH_OFF;
				end
			endcase
		end
	end

	// Source handshake, choosing fast or interlocked per byte.
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sh_st_r     <= gpib_fast_pkg::SH_IDLE;
			cnt_r       <= '0;
			fast_byte_r <= 1'b0;
			dav_rel_r   <= 1'b1;
			dio_r       <= 8'h00;
			dio_drive_r <= 1'b0;
			tx_ready_r  <= 1'b0;
		end else if (ce_i) begin
			tx_ready_r <= 1'b0;
			if (atn || !talk_addr_i) begin
				sh_st_r     <= gpib_fast_pkg::SH_IDLE;
				dav_rel_r   <= 1'b1;
				dio_drive_r <= 1'b0;
			end else begin
				unique case (sh_st_r)
					gpib_fast_pkg::SH_IDLE: begin
						dav_rel_r <= 1'b1;
						if (tx_valid_i && !tx_ready_r) begin
							tx_ready_r  <= 1'b1;
							dio_r       <= ~tx_data_i;
							dio_drive_r <= 1'b1;
							// Fast only when every listener has released acceptance early.
							fast_byte_r <= cfg_done_r & ndac_rel & nrfd_rel;
							cnt_r       <= (cfg_done_r & ndac_rel & nrfd_rel)
								? fast_settle_r : gpib_fast_pkg::STD_SETTLE_CYC;
							sh_st_r     <= gpib_fast_pkg::SH_SETTLE;
						end
					end
					gpib_fast_pkg::SH_SETTLE: begin
						if (cnt_r > 10'h001) begin
							cnt_r <= cnt_r - 10'h001;
						end else if (nrfd_rel) begin
							dav_rel_r <= 1'b0;
							cnt_r     <= gpib_fast_pkg::FAST_DAV_PULSE_CYC;
							sh_st_r   <= fast_byte_r ? gpib_fast_pkg::SH_FAST_DAV
								: gpib_fast_pkg::SH_STD_DAV;
						end
					end
					gpib_fast_pkg::SH_STD_DAV: begin
						if (ndac_rel) begin
							dav_rel_r   <= 1'b1;
							dio_drive_r <= 1'b0;
							sh_st_r     <= gpib_fast_pkg::SH_IDLE;
						end
					end
					gpib_fast_pkg::SH_FAST_DAV: begin
						// Short fixed pulse with no wait on acceptance keeps the byte rate up.
						if (cnt_r > 10'h001) begin
							cnt_r <= cnt_r - 10'h001;
						end else begin
							dav_rel_r <= 1'b1;
							cnt_r     <= gpib_fast_pkg::FAST_HOLD_CYC;
							sh_st_r   <= gpib_fast_pkg::SH_FAST_HOLD;
						end
					end
					gpib_fast_pkg::SH_FAST_HOLD: begin
						if (cnt_r > 10'h001) begin
							cnt_r <= cnt_r - 10'h001;
						end else begin
							dio_drive_r <= 1'b0;
							sh_st_r     <= gpib_fast_pkg::SH_IDLE;
						end
					end
					default: begin
						sh_st_r <= gpib_fast_pkg::SH_IDLE;
					end
				endcase
			end
		end
	end

	assign dio_o         = dio_r;
	assign dio_oe_n_o    = ~dio_drive_r;
	assign dav_n_o       = dav_rel_r;
	assign dav_oe_n_o    = dav_rel_r;
	assign nrfd_n_o      = nrfd_rel_r;
	assign nrfd_oe_n_o   = nrfd_rel_r;
	assign ndac_n_o      = ndac_rel_r;
	assign ndac_oe_n_o   = ndac_rel_r;
	assign rx_valid_o    = rx_valid_r;
	assign rx_data_o     = rx_data_r;
	assign rx_cmd_o      = rx_cmd_r;
	assign tx_ready_o    = tx_ready_r;
	assign fast_cfg_o    = cfg_done_r;
	assign cable_len_o   = cable_len_r;
	assign fast_active_o = fast_byte_r;

endmodule // gpib_fast_cfg

// >>> gpib_fast_cfg_props.sv
// Assertions on the fast configuration block ports.
// Assumes one clock domain; bound to every instance of the block.
`timescale 1ns/1ps
module gpib_fast_cfg_props (
	// Clock and reset
	input wire logic       mclk_i,
	input wire logic       sys_rst_i,
	// Observed ports
	input wire logic       ndac_n_i,
	input wire logic       dav_n_o,
	input wire logic       nrfd_n_o,
	input wire logic       ndac_n_o,
	input wire logic       dio_oe_n_o,
	input wire logic       rx_valid_o,
	input wire logic [7:0] rx_data_o,
	input wire logic       rx_cmd_o,
	input wire logic       tx_ready_o,
	input wire logic       fast_cfg_o,
	input wire logic [3:0] cable_len_o,
	input wire logic       fast_active_o
);
	// Set when an accepted command byte is the enable message while not already armed; any other command byte clears it.
	logic armed_r;
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			armed_r <= 1'b0;
		end else if (rx_valid_o && rx_cmd_o) begin
			armed_r <= !armed_r && (rx_data_o[6:0] == gpib_fast_pkg::CFG_ENABLE_MSG);
		end
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	sequence sec_cfg_s;
		rx_valid_o && rx_cmd_o && armed_r && rx_data_o[6:4] == gpib_fast_pkg::SEC_CFG_GROUP;
	endsequence
	sequence dav_pulse_s;
		(!dav_n_o)[*8] ##1 dav_n_o;
	endsequence
	chk_len_latch: assert property (
		sec_cfg_s |-> fast_cfg_o && cable_len_o == rx_data_o[3:0]) else $error("len not latched");
	chk_other_keeps: assert property (
		rx_valid_o && rx_cmd_o && !(armed_r && rx_data_o[6:4] == gpib_fast_pkg::SEC_CFG_GROUP)
		|-> $stable(cable_len_o) && $stable(fast_cfg_o)) else $error("setting changed");
	chk_len_stable: assert property (
		!rx_valid_o |-> $stable(cable_len_o)) else $error("len moved alone");
	chk_fast_needs_cfg: assert property (
		$fell(dav_n_o) && !fast_cfg_o |-> !fast_active_o) else $error("fast unconfigured");
	chk_fast_pulse: assert property (
		$fell(dav_n_o) && fast_active_o |-> dav_pulse_s) else $error("fast pulse length");
	chk_std_interlock: assert property (
		$rose(dav_n_o) && !fast_active_o |-> $past(ndac_n_i)) else $error("dav released early");
	chk_cmd_interlocked: assert property (
		rx_valid_o && rx_cmd_o |-> !nrfd_n_o && ndac_n_o) else $error("cmd not interlocked");
	chk_tx_drive: assert property (
		tx_ready_o |-> !dio_oe_n_o ##1 !tx_ready_o) else $error("tx take");
endmodule // gpib_fast_cfg_props

bind gpib_fast_cfg gpib_fast_cfg_props chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
	.ndac_n_i(ndac_n_i), .dav_n_o(dav_n_o), .nrfd_n_o(nrfd_n_o), .ndac_n_o(ndac_n_o),
	.dio_oe_n_o(dio_oe_n_o), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
	.rx_cmd_o(rx_cmd_o), .tx_ready_o(tx_ready_o), .fast_cfg_o(fast_cfg_o),
	.cable_len_o(cable_len_o), .fast_active_o(fast_active_o));

// >>> gpib_ctl_model.sv
// Bus controller and peer listener model.
// Assumes the bench resolves each line as the AND of all drivers.
`timescale 1ns/1ps
module gpib_ctl_model (
	// Clock
	input  wire logic       mclk_i,
	// Resolved lines
	input  wire logic       nrfd_w_i,
	input  wire logic       ndac_w_i,
	input  wire logic       dav_w_i,
	input  wire logic [7:0] dio_w_i,
	// Own drivers
	output logic            atn_n_o,
	output logic            dav_n_o,
	output logic [7:0]      dio_n_o,
	output logic            nrfd_n_o,
	output logic            ndac_n_o
);
	initial begin
		atn_n_o = 1'b1;
		dav_n_o = 1'b1;
		dio_n_o = 8'hff;
		nrfd_n_o = 1'b1;
		ndac_n_o = 1'b1;
	end
	task automatic atn_set(input logic on);
		atn_n_o = ~on;
		repeat (8) @(negedge mclk_i);
	endtask
	// Released data lines float high through the pull-ups.
	task automatic send_cmd(input logic [7:0] b);
		dio_n_o = ~b;
		for (int i = 0; i < 99 && !(nrfd_w_i === 1'b1 && ndac_w_i === 1'b0); i++) @(negedge mclk_i);
		repeat (4) @(negedge mclk_i);
		dav_n_o = 1'b0;
		@(negedge mclk_i);
		for (int i = 0; i < 99 && ndac_w_i !== 1'b1; i++) @(negedge mclk_i);
		dav_n_o = 1'b1;
		dio_n_o = 8'hff;
		for (int i = 0; i < 99 && ndac_w_i !== 1'b0; i++) @(negedge mclk_i);
	endtask
	// A fast-capable peer shows itself by releasing NDAC while ready.
	task automatic set_ready(input logic fast);
		nrfd_n_o = 1'b1;
		ndac_n_o = fast;
	endtask
	task automatic listen(output logic [7:0] got);
		for (int i = 0; i < 999 && dav_w_i !== 1'b0; i++) @(negedge mclk_i);
		got = ~dio_w_i;
		ndac_n_o = 1'b1;
		for (int i = 0; i < 99 && dav_w_i !== 1'b1; i++) @(negedge mclk_i);
		ndac_n_o = 1'b0;
	endtask
endmodule // gpib_ctl_model

// >>> gpib_fast_transfer_config_test.sv
// Self-checking bench for the fast configuration block.
// Assumes the controller model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module gpib_fast_transfer_config_test;
	logic       mclk_i, sys_rst_i, talk_addr_i, tx_valid_i, c_atn, c_dav, c_nrfd, c_ndac;
	logic [7:0] tx_data_i, dio_o, rx_data_o, c_dio, dio_w;
	logic       dio_oe_n_o, dav_n_o, dav_oe_n_o, nrfd_n_o, nrfd_oe_n_o, ndac_n_o, ndac_oe_n_o;
	logic       rx_valid_o, rx_cmd_o, tx_ready_o, fast_cfg_o, fast_active_o;
	logic       dav_w, nrfd_w, ndac_w;
	logic       ce_i, listen_addr_i, rx_ready_i;
	int         rx_count;
	logic [3:0] cable_len_o;
	int         bad_count, compares;
	assign dio_w = (dio_oe_n_o ? 8'hff : dio_o) & c_dio;
	assign dav_w = (dav_oe_n_o | dav_n_o) & c_dav;
	assign nrfd_w = (nrfd_oe_n_o | nrfd_n_o) & c_nrfd;
	assign ndac_w = (ndac_oe_n_o | ndac_n_o) & c_ndac;
	gpib_ctl_model ctl (.mclk_i(mclk_i), .nrfd_w_i(nrfd_w), .ndac_w_i(ndac_w), .dav_w_i(dav_w),
		.dio_w_i(dio_w), .atn_n_o(c_atn), .dav_n_o(c_dav), .dio_n_o(c_dio), .nrfd_n_o(c_nrfd),
		.ndac_n_o(c_ndac));
	gpib_fast_cfg DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .dio_i(dio_w),
		.dio_o(dio_o), .dio_oe_n_o(dio_oe_n_o), .atn_n_i(c_atn), .dav_n_i(dav_w),
		.dav_n_o(dav_n_o), .dav_oe_n_o(dav_oe_n_o), .nrfd_n_i(nrfd_w), .nrfd_n_o(nrfd_n_o),
		.nrfd_oe_n_o(nrfd_oe_n_o), .ndac_n_i(ndac_w), .ndac_n_o(ndac_n_o),
		.ndac_oe_n_o(ndac_oe_n_o), .talk_addr_i(talk_addr_i), .listen_addr_i(listen_addr_i),
		.rx_ready_i(rx_ready_i), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
		.rx_cmd_o(rx_cmd_o),
		.tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o),
		.fast_cfg_o(fast_cfg_o), .cable_len_o(cable_len_o), .fast_active_o(fast_active_o));
	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end
	// Received-byte pulses last one cycle, so they are counted where they stand.
	always @(negedge mclk_i) begin
		if (rx_valid_o === 1'b1) begin
			rx_count++;
		end
	end
	task automatic check(input logic [9:0] seen, input logic [9:0] want, input string what);
		compares++;
		if (seen !== want) begin
			bad_count++;
			$display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
		end
	endtask
	task automatic end_of_test();
		if (bad_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic cmd(input logic [7:0] b, input logic cfg, input logic [3:0] len);
		int seen;
		seen = rx_count;
		ctl.send_cmd(b);
		check(10'(rx_count - seen), 10'd1, "cmd pulses");
		check(rx_data_o, b, "rx byte");
		check(rx_cmd_o, 1'b1, "cmd flag");
		check(fast_cfg_o, cfg, "cfg flag");
		check(cable_len_o, len, "length");
	endtask
	// A lone, repeated or foreign second byte must leave the setting alone.
	task automatic t_config();
		ctl.atn_set(1'b1);
		cmd(8'h64, 1'b0, 4'h0);
		cmd(8'h1f, 1'b0, 4'h0);
		cmd(8'h64, 1'b1, 4'h4);
		cmd(8'h1f, 1'b1, 4'h4);
		cmd(8'h1f, 1'b1, 4'h4);
		cmd(8'h63, 1'b1, 4'h4);
		cmd(8'h1f, 1'b1, 4'h4);
		cmd(8'h20, 1'b1, 4'h4);
		cmd(8'h9f, 1'b1, 4'h4);
		cmd(8'h6f, 1'b1, 4'hf);
		ctl.atn_set(1'b0);
	endtask
	// Unconfigured listener: refuses while not ready, then takes one byte interlocked.
	task automatic t_listen();
		int seen;
		listen_addr_i = 1'b1;
		rx_ready_i = 1'b0;
		repeat (12) @(negedge mclk_i);
		check(nrfd_w, 1'b0, "nrfd held");
		check(ndac_oe_n_o, 1'b0, "std acceptor");
		rx_ready_i = 1'b1;
		seen = rx_count;
		ctl.send_cmd(8'h5a);
		check(rx_data_o, 8'h5a, "rx data");
		check(rx_cmd_o, 1'b0, "data flag");
		check(10'(rx_count - seen), 10'd1, "rx pulses");
		listen_addr_i = 1'b0;
		repeat (8) @(negedge mclk_i);
	endtask
	// Configured and ready listener shows fast capability on the acceptance line.
	task automatic t_fast_ready();
		listen_addr_i = 1'b1;
		repeat (8) @(negedge mclk_i);
		check(ndac_oe_n_o, 1'b1, "fast acceptor");
		check(nrfd_oe_n_o, 1'b1, "ready shown");
		listen_addr_i = 1'b0;
		repeat (8) @(negedge mclk_i);
	endtask
	// Settle is 400 cycles interlocked, 8 plus one per metre fast.
	task automatic talk(input logic pf, input logic [7:0] b, input logic fw, input logic [3:0] len);
		int n;
		logic [7:0] got;
		talk_addr_i = 1'b1;
		ctl.set_ready(pf);
		repeat (8) @(negedge mclk_i);
		tx_data_i = b;
		tx_valid_i = 1'b1;
		fork
			ctl.listen(got);
			begin
				for (n = 0; n < 50 && tx_ready_o !== 1'b1; n++) @(negedge mclk_i);
				tx_valid_i = 1'b0;
				for (n = 0; n < 999 && dav_n_o !== 1'b0; n++) @(negedge mclk_i);
			end
		join
		check(got, b, "tx byte");
		check(fast_active_o, fw, "mode");
		check(10'(n), fw ? 10'd8 + 10'(len) : 10'd400, "settle");
		repeat (30) @(negedge mclk_i);
		check(dio_oe_n_o, 1'b1, "data off");
		talk_addr_i = 1'b0;
		ctl.set_ready(1'b1);
		repeat (8) @(negedge mclk_i);
	endtask
	initial begin
		sys_rst_i = 1'b1;
		talk_addr_i = 1'b0;
		tx_valid_i = 1'b0;
		tx_data_i = 8'h00;
		ce_i = 1'b1;
		listen_addr_i = 1'b0;
		rx_ready_i = 1'b1;
		repeat (20) @(negedge mclk_i);
		sys_rst_i = 1'b0;
		repeat (2) @(negedge mclk_i);
		check(fast_cfg_o, 1'b0, "reset cfg");
		check(cable_len_o, 4'h0, "reset len");
		talk(1'b1, 8'ha5, 1'b0, 4'h0);
		t_listen();
		t_config();
		t_fast_ready();
		talk(1'b0, 8'h3c, 1'b0, 4'hf);
		talk(1'b1, 8'hc3, 1'b1, 4'hf);
		end_of_test();
	end
	// The tests need about 1300 cycles; ten thousand means a hang.
	initial begin
		repeat (10000) @(posedge mclk_i);
		bad_count++;
		end_of_test();
	end
endmodule // gpib_fast_transfer_config_test
